//--- verilog/addr_map_defines.svh
// Purpose: Constants for the SDRAM address mapper (field positions, pin layout).
// Assumes: Host byte addresses of 32 bits; 64-bit memory data path.
// Notes: Types live in addr_map_pkg.
// How it works
// - 16M two-bank row: bank select from bit 11, lines 10..0 from bits 22..12.
// - 64/128M two-bank row: bank select bit 11, lines 12..0 from bits 24..12.
// - 64/128M two-bank column: lines 12..10 low, 9..8 bits 26..25, rest 10..3.
// - Four-bank row: bank selects bits 11 and 12, lines 11..0 from bits 24..13.
// - Four-bank column: banks kept, lines 11..10 low, 9..8 bits 26..25, rest 10..3.
// - Memory clock comes from internal PLL and drives the clock output directly.
// - Graphics memory starts bank 0, host memory sits above; bank 0 always used.
// - Large parts reuse third and fourth chip selects as address or bank lines.
`ifndef ADDR_MAP_DEFINES_SVH
`define ADDR_MAP_DEFINES_SVH
`define AM_HOST_AW 32
`define AM_LINES_W 13
`define AM_BANK_LO_BIT 11
`define AM_BANK_HI_BIT 12
`define AM_COL_LO 3
`define AM_COL_HI 10
`define AM_ROW16_LO 12
`define AM_ROW16_HI 22
`define AM_ROW64_LO 12
`define AM_ROW64_HI 24
`define AM_ROW4B_LO 13
`define AM_ROW4B_HI 24
`define AM_C16_HI 24
`define AM_C16_LO 23
`define AM_C64_HI 26
`define AM_C64_LO 25
`define AM_LINE_TOP12 12
`define AM_LINE_TOP11 11
`define AM_CHIP_SEL_W 4
`define AM_CS_IDLE 4'h000F
`endif

//--- verilog/addr_map_pkg.sv
// Purpose: Types for the SDRAM address mapper.
// Assumes: Used by the mapper and the bench files; mem_clock_out does not import it.
// Notes: Geometry select encoding is free; the mapper decodes it only by name.
package addr_map_pkg;
  typedef enum logic [1:0] {
    GEOM_16M_2B,
    GEOM_64M_2B,
    GEOM_64M_4B
  } geom_e;
  typedef logic [12:0] lines_t;
endpackage

//--- verilog/mem_clock_out.sv
// Purpose: Forward the PLL memory clock straight to the output pin.
// Assumes: The PLL is outside this logic and feeds pll_clk.
// Notes: No gating or register, so no added skew beyond the pad.
`timescale 1ns/1ps
module mem_clock_out (
  input wire logic pll_clk,
  output logic mem_clock_out
);
  // Direct path keeps the returned copy a faithful board-delayed image
  assign mem_clock_out = pll_clk;
endmodule // mem_clock_out

//--- verilog/sdram_address_mapper.sv
// Purpose: Split a host byte address into bank select, row and column lines.
// Assumes: Runs on the returned memory clock; requests are one-cycle pulses.
// Notes: Outputs except mem_clock_out are registered one cycle after the request; geometry is latched
//   at reset release so a live change cannot split a row from its column.
`timescale 1ns/1ps
`include "addr_map_defines.svh"
module sdram_address_mapper #(
  parameter int HOST_AW = `AM_HOST_AW,
  parameter int GRAPHICS_BYTES = 32'h0040_0000
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic pll_clk,
  input wire addr_map_pkg::geom_e geom_sel,
  input wire logic [HOST_AW-1:0] host_addr,
  input wire logic graphics_access,
  input wire logic req_valid,
  input wire logic col_phase,
  output logic mem_clock_out,
  output logic map_valid,
  output logic bank_select_low,
  output logic bank_select_high,
  output addr_map_pkg::lines_t sdram_row_col_lines,
  output logic chip_select_third_n,
  output logic chip_select_fourth_n,
  output logic upper_bank_usable
);
  import addr_map_pkg::*;

  typedef struct packed {
    logic cfg_taken;
    geom_e geom;
    logic valid;
    logic ba0;
    logic ba1;
    lines_t lines;
    logic cs3_n;
    logic cs4_n;
  } state_s;

  state_s st_q;
  state_s st_d;
  logic [HOST_AW-1:0] eff_addr;

  // Memory clock path kept in its own cell
  mem_clock_out u_clk (
    .pll_clk(pll_clk),
    .mem_clock_out(mem_clock_out)
  );

  // Host memory sits above the graphics area at the base of bank 0
  assign eff_addr = graphics_access ? host_addr
                                    : host_addr + HOST_AW'(GRAPHICS_BYTES);

  // Column low eight lines are common to every geometry
  function automatic lines_t col_low(input logic [HOST_AW-1:0] a);
    lines_t r;
    r = '0;
    r[7:0] = a[`AM_COL_HI:`AM_COL_LO];
    return r;
  endfunction

  // Next-state: one mapping per geometry, chosen for every access alike
  always_comb begin
    st_d = st_q;
    st_d.valid = req_valid;
    if (!st_q.cfg_taken) begin
      st_d.geom = geom_sel;
      st_d.cfg_taken = 1'b1;
    end
    if (req_valid) begin
      st_d.ba0 = eff_addr[`AM_BANK_LO_BIT];
      st_d.ba1 = 1'b0;
      st_d.lines = col_low(eff_addr);
      case (st_q.geom)
        GEOM_16M_2B: begin
          if (!col_phase) begin
            st_d.lines = '0;
            st_d.lines[10:0] = eff_addr[`AM_ROW16_HI:`AM_ROW16_LO];
          end else begin
            st_d.lines[9:8] = eff_addr[`AM_C16_HI:`AM_C16_LO];
          end
        end
        GEOM_64M_2B: begin
          if (!col_phase) begin
            st_d.lines = eff_addr[`AM_ROW64_HI:`AM_ROW64_LO];
          end else begin
            st_d.lines[9:8] = eff_addr[`AM_C64_HI:`AM_C64_LO];
          end
        end
        GEOM_64M_4B: begin
          st_d.ba1 = eff_addr[`AM_BANK_HI_BIT];
          if (!col_phase) begin
            st_d.lines = '0;
            st_d.lines[11:0] = eff_addr[`AM_ROW4B_HI:`AM_ROW4B_LO];
          end else begin
            st_d.lines[9:8] = eff_addr[`AM_C64_HI:`AM_C64_LO];
          end
        end
        default: begin
          st_d.lines = '0;
        end
      endcase
    end
    // Large parts lend the spare chip selects to address and bank lines
    case (st_q.geom)
      GEOM_64M_2B: begin
        st_d.cs3_n = st_d.lines[`AM_LINE_TOP11];
        st_d.cs4_n = st_d.lines[`AM_LINE_TOP12];
      end
      GEOM_64M_4B: begin
        st_d.cs3_n = st_d.lines[`AM_LINE_TOP11];
        st_d.cs4_n = st_d.ba1;
      end
      default: begin
        st_d.cs3_n = 1'b1;
        st_d.cs4_n = 1'b1;
      end
    endcase
  end

  // Synchronous reset; geometry is sampled on the first cycle after release
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_q <= '{cfg_taken: 1'b0, geom: GEOM_16M_2B, valid: 1'b0, ba0: 1'b0,
                ba1: 1'b0, lines: '0, cs3_n: 1'b1, cs4_n: 1'b1};
    end else begin
      st_q <= st_d;
    end
  end

  assign map_valid = st_q.valid;
  assign bank_select_low = st_q.ba0;
  assign bank_select_high = st_q.ba1;
  assign sdram_row_col_lines = st_q.lines;
  assign chip_select_third_n = st_q.cs3_n;
  assign chip_select_fourth_n = st_q.cs4_n;
  // Only 16M parts leave all four chip selects for banks
  assign upper_bank_usable = (st_q.geom == GEOM_16M_2B);
endmodule // sdram_address_mapper

//--- tb/addr_map_checker.sv
// Purpose: Port checks for the address mapper
// Assumes: geom_sel steady between resets
// Notes: Graphics accesses only, so no offset enters
`timescale 1ns/1ps
module addr_map_checker
  import addr_map_pkg::*;
#(parameter int HOST_AW = 32) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire geom_e geom_sel,
  input wire logic [HOST_AW-1:0] host_addr,
  input wire logic graphics_access,
  input wire logic req_valid,
  input wire logic col_phase,
  input wire logic map_valid,
  input wire logic bank_select_low,
  input wire logic bank_select_high,
  input wire lines_t sdram_row_col_lines,
  input wire logic chip_select_third_n,
  input wire logic chip_select_fourth_n,
  input wire logic upper_bank_usable
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Shorthands for request and geometry
  wire logic rq = req_valid & graphics_access;
  wire logic g16 = geom_sel == GEOM_16M_2B;
  wire logic g4 = geom_sel == GEOM_64M_4B;
  property p_ans; req_valid |=> map_valid ##1 map_valid == $past(req_valid); endproperty
  a_ans: assert property (p_ans) else $error("answer");
  property p_r16; rq & !col_phase & g16 |=> {bank_select_low, sdram_row_col_lines} ==
    {$past(host_addr[11]), 2'h0, $past(host_addr[22:12])}; endproperty
  a_r16: assert property (p_r16) else $error("row16");
  property p_c16; rq & col_phase & g16 |=> sdram_row_col_lines ==
    {3'h0, $past(host_addr[24:23]), $past(host_addr[10:3])}; endproperty
  a_c16: assert property (p_c16) else $error("col16");
  property p_r64; rq & !col_phase & geom_sel == GEOM_64M_2B |=>
    sdram_row_col_lines == $past(host_addr[24:12]); endproperty
  a_r64: assert property (p_r64) else $error("row64");
  property p_c64; rq & col_phase & !g16 |=> sdram_row_col_lines ==
    {3'h0, $past(host_addr[26:25]), $past(host_addr[10:3])}; endproperty
  a_c64: assert property (p_c64) else $error("col64");
  property p_r4; rq & !col_phase & g4 |=> {sdram_row_col_lines[11:0], bank_select_high,
    bank_select_low} == $past(host_addr[24:11]); endproperty
  a_r4: assert property (p_r4) else $error("row4");
  property p_cs; map_valid & !g16 |-> chip_select_third_n == sdram_row_col_lines[11] &&
    chip_select_fourth_n == (g4 ? bank_select_high : sdram_row_col_lines[12]); endproperty
  a_cs: assert property (p_cs) else $error("cs");
  property p_ub; map_valid |-> upper_bank_usable == g16 &&
    (!g16 || chip_select_third_n & chip_select_fourth_n); endproperty
  a_ub: assert property (p_ub) else $error("banks");
endmodule // addr_map_checker
bind sdram_address_mapper addr_map_checker #(.HOST_AW(HOST_AW)) addr_map_checker_i (.*);

//--- tb/sdram_clock_return.sv
// Purpose: Board rebuffer of the memory clock
// Assumes: One copy feeds the mapper
// Notes: DIMM skew not modelled
`timescale 1ns/1ps
module sdram_clock_return (
  input wire logic mem_clock_out,
  output logic clk_sys
);
  // Buffer delay; a dead clock pin stalls the bench
  assign #1 clk_sys = mem_clock_out;
endmodule // sdram_clock_return

//--- tb/testbench.sv
// Purpose: Self-checking bench for the mapper
// Assumes: Clock returns via board model
// Notes: Expectations rebuilt from the maps
`timescale 1ns/1ps
module testbench;
  import addr_map_pkg::*;
  logic pll_clk = 1'h0, reset_n = 1'h0, graphics_access = 1'h1, req_valid = 1'h0;
  logic col_phase = 1'h0;
  geom_e geom_sel = GEOM_16M_2B;
  logic [31:0] host_addr = 32'h0;
  wire logic clk_sys, mem_clock_out, map_valid, bank_select_low, bank_select_high;
  wire logic chip_select_third_n, chip_select_fourth_n, upper_bank_usable;
  wire lines_t sdram_row_col_lines;
  int n_fail = 0, cmp_count = 0, cycles = 0;
  sdram_address_mapper sdram_address_mapper_i (.*);
  sdram_clock_return sdram_clock_return_i (.*);
  always #5 pll_clk = ~pll_clk;
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Hang guard, far past the run length
  always @(posedge clk_sys) if (++cycles == 500) begin
    n_fail++;
    report_and_stop;
  end
  function automatic logic [18:0] mapped(geom_e g, logic [31:0] a, logic c);
    logic [12:0] l;
    logic s;
    logic h;
    s = g == GEOM_16M_2B;
    h = g == GEOM_64M_4B && a[12];
    if (c) l = {3'h0, s ? a[24:23] : a[26:25], a[10:3]};
    else if (s) l = {2'h0, a[22:12]};
    else l = g == GEOM_64M_2B ? a[24:12] : {1'h0, a[24:13]};
    return {1'h1, h, a[11], s | (g == GEOM_64M_4B ? h : l[12]), s | l[11], s, l};
  endfunction
  task automatic access(input logic [31:0] a, input logic c, input logic ga);
    @(posedge clk_sys) begin
      host_addr <= a;
      col_phase <= c;
      graphics_access <= ga;
      req_valid <= 1'h1;
    end
    @(posedge clk_sys) req_valid <= 1'h0;
    #1 cmp_count++;
    if ({map_valid, bank_select_high, bank_select_low, chip_select_fourth_n,
        chip_select_third_n, upper_bank_usable, sdram_row_col_lines} !==
        mapped(geom_sel, ga ? a : a + 32'h0040_0000, c)) begin
      n_fail++;
      $display("unexpected t=%0t lines=%h", $time, sdram_row_col_lines);
    end
  endtask
  task automatic t_geom(input geom_e g);
    @(posedge clk_sys) begin
      reset_n <= 1'h0;
      geom_sel <= g;
    end
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'h1;
    @(posedge clk_sys);
    access(32'h0555_5AA8, 1'h0, 1'h1);
    access(32'h06AA_B550, 1'h1, 1'h1);
    access(32'h06AA_B550, 1'h0, 1'h0);
  endtask
  initial begin
    t_geom(GEOM_16M_2B);
    t_geom(GEOM_64M_2B);
    t_geom(GEOM_64M_4B);
    report_and_stop;
  end
endmodule // testbench
